// >>> hdl/cus_pkg.sv
// Constants, register map and state encodings for the charge termination and usage statistics block.
package cus_pkg;
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned TICK_S          = 1;
  localparam int unsigned TICK_CYCLES_DEF = TICK_S * CLK_HZ;

  localparam int unsigned MAS_PER_MAH      = 3600;
  localparam int unsigned TAPER_MIN_UAH    = 250;
  localparam logic [31:0] TAPER_MIN_MAS    = 32'(TAPER_MIN_UAH * MAS_PER_MAH / 1000);
  localparam logic [7:0]  LOW_SOC_PCT      = 8'h32;
  localparam logic [7:0]  TAPER_MODE_CODE  = 8'hFF;

  localparam logic [7:0] A_CTRL       = 8'h00;
  localparam logic [7:0] A_STATUS     = 8'h02;
  localparam logic [7:0] A_CHG_VOLT   = 8'h04;
  localparam logic [7:0] A_TAPER_VOLT = 8'h06;
  localparam logic [7:0] A_TAPER_CUR  = 8'h08;
  localparam logic [7:0] A_MIN_CAP    = 8'h0A;
  localparam logic [7:0] A_TAPER_WIN  = 8'h0C;
  localparam logic [7:0] A_SET_PCT    = 8'h0E;
  localparam logic [7:0] A_CLR_PCT    = 8'h10;
  localparam logic [7:0] A_INIT_STBY  = 8'h12;
  localparam logic [7:0] A_ML_SEED    = 8'h14;
  localparam logic [7:0] A_DEADBAND   = 8'h16;
  localparam logic [7:0] A_CC_THRESH  = 8'h18;
  localparam logic [7:0] A_FCC        = 8'h1A;
  localparam logic [7:0] A_STBY_CUR   = 8'h1C;
  localparam logic [7:0] A_MAXLOAD    = 8'h1E;
  localparam logic [7:0] A_CYCLES     = 8'h20;
  localparam logic [7:0] A_REM_CAP    = 8'h22;
  localparam logic [7:0] A_DSG_ACC    = 8'h24;
  localparam logic [7:0] A_NAME_FIRST = 8'h63;
  localparam logic [7:0] A_NAME_LAST  = 8'h69;
  localparam int unsigned NAME_LEN    = 7;

  localparam int unsigned CTRL_REMAINING_FROM_FULL_ON_TERM_BIT = 0;
  localparam int unsigned ST_FULL_BIT    = 0;
  localparam int unsigned ST_CHG_BIT     = 1;
  localparam int unsigned ST_ARMED_BIT   = 2;
  localparam int unsigned ST_FIRST_BIT   = 3;

  localparam logic [15:0] RST_CTRL       = 16'h0001;
  localparam logic [15:0] RST_CHG_VOLT   = 16'h1068;
  localparam logic [15:0] RST_TAPER_VOLT = 16'h0064;
  localparam logic [15:0] RST_TAPER_CUR  = 16'h0064;
  localparam logic [15:0] RST_MIN_CAP    = 16'h0384;
  localparam logic [15:0] RST_TAPER_WIN  = 16'h0028;
  localparam logic [7:0]  RST_SET_PCT    = 8'hFF;
  localparam logic [7:0]  RST_CLR_PCT    = 8'h62;
  localparam logic [15:0] RST_INIT_STBY  = 16'hFFF6;
  localparam logic [15:0] RST_ML_SEED    = 16'hFE0C;
  localparam logic [15:0] RST_DEADBAND   = 16'h0005;
  localparam logic [15:0] RST_CC_THRESH  = 16'h0384;
  localparam logic [15:0] RST_FCC        = 16'h03E8;

  typedef enum logic [1:0] {
    TP_WAIT   = 2'b00,
    TP_FIRST  = 2'b01,
    TP_SECOND = 2'b11
  } cus_taper_e;
endpackage

// >>> hdl/cus_gauge.sv
// Charge termination detection, full-charge flag control and usage statistics.
`timescale 1ns/1ps
// Notes on behaviour
// - Both consecutive taper windows must average current below the taper current.
// - Each of those windows must accumulate more than 0.25 mAh of charge.
// - Voltage must exceed charging voltage minus taper voltage margin.
// - Termination sets the full-charge flag and clears the charging flag.
// - On termination with the control bit set, remaining capacity loads full capacity.
// - Requirements must hold for two taper windows; window defaults to 40 s.
// - Detection starts only after charge since start exceeds minimum taper capacity.
// - Qualification starts only when voltage is above the charging reference less margin.
// - Set percentage of -1 selects taper; otherwise full flag follows state of charge.
// - While discharging, full flag clears when state of charge reaches clear percentage.
// - Standby starts at seed; updates each second inside deadband to twice seed range.
// - Max-load starts at seed; replaced when discharge current magnitude exceeds both the seed and the stored max-load.
// - Full charge after discharge below 50% averages max-load with its seed.
// - Discharged capacity accumulates; cycle count increments when it reaches threshold.
// - The discharge accumulator clears only when it equals threshold and count increments.
// - Addresses 0x63 to 0x69 return a seven character name; no other effect.
// - Taper current threshold defaults to 100 mA.
// - Cycle-count threshold defaults to 900 mAh.
// - Charging voltage defaults to 4200 mV and forms the termination voltage reference.
module cus_gauge #(
  parameter int unsigned TICK_CYCLES = cus_pkg::TICK_CYCLES_DEF,
  parameter logic [55:0] NAME_INIT   = 56'h47_41_55_47_45_30_31
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic signed [15:0] cur_ma,
  input  wire logic [15:0]       volt_mv,
  input  wire logic [7:0]        soc_pct,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  output logic                   full_charge_flag,
  output logic                   charging_flag
);
  // Name bytes: the parameter default is arbitrary and identifies no product.
  logic [7:0]  name_mem [cus_pkg::NAME_LEN];
  logic [15:0] ctrl_r, chg_volt_r, taper_volt_r, taper_cur_r, min_cap_r, taper_win_r;
  logic [7:0]  set_pct_r, clr_pct_r;
  logic [15:0] init_stby_r, ml_seed_r, deadband_r, cc_thresh_r, fcc_r;
  logic [15:0] stby_r, maxload_r, cycles_r, rem_cap_r, dsg_mah_r;
  logic [11:0] dsg_mas_r;
  logic [31:0] tick_cnt_r;
  logic        tick;
  logic [31:0] start_chg_r, win_chg_r;
  logic signed [32:0] win_sum_r;
  logic [15:0] win_sec_r;
  logic        win_vok_r;
  logic        fc_r, chg_r, low_seen_r;
  cus_pkg::cus_taper_e tp_r;

  logic [15:0] cur_mag, seed_mag, ml_mag;
  logic        volt_ok, taper_mode, armed, win_end, pass, term_now;
  logic        full_set_percent, fc_clr, dsg, chgi;
  logic signed [32:0] cur_ext, sum_now, thr_now;
  logic [31:0] chg_now;
  logic [16:0] ml_avg;

  always_comb begin
    cur_mag    = cur_ma[15] ? 16'(-cur_ma) : cur_ma;
    seed_mag   = ml_seed_r[15] ? 16'(-ml_seed_r) : ml_seed_r;
    ml_mag     = maxload_r[15] ? 16'(-maxload_r) : maxload_r;
    dsg        = cur_ma[15];
    chgi       = !cur_ma[15] && (cur_ma != 16'sh0000);
    cur_ext    = 33'(cur_ma);
    volt_ok    = {1'b0, volt_mv} > (17'(chg_volt_r) - 17'(taper_volt_r));
    taper_mode = set_pct_r == cus_pkg::TAPER_MODE_CODE;
    armed      = chgi && volt_ok && (start_chg_r > 32'(min_cap_r));
    win_end    = (win_sec_r + 16'h0001) >= taper_win_r;
    sum_now    = win_sum_r + cur_ext;
    chg_now    = win_chg_r + (chgi ? 32'(cur_ma) : 32'h0000_0000);
    thr_now    = 33'(32'(taper_cur_r) * 32'(taper_win_r));
    // Window sum compared against threshold times length avoids a divider.
    pass       = (sum_now < thr_now) && (chg_now > cus_pkg::TAPER_MIN_MAS)
                 && win_vok_r && volt_ok;
    term_now   = tick && chgi && (tp_r == cus_pkg::TP_SECOND) && win_end && pass
                 && taper_mode;
    full_set_percent     = term_now || (!taper_mode && chgi && soc_pct >= set_pct_r);
    fc_clr     = dsg && soc_pct <= clr_pct_r;
    ml_avg     = (17'(signed'(maxload_r)) + 17'(signed'(ml_seed_r))) >>> 1;
  end

  // One-second timebase.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tick_cnt_r <= 32'h0000_0000;
      tick       <= 1'b0;
    end else if (tick_cnt_r >= TICK_CYCLES - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick       <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick       <= 1'b0;
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrl_r       <= cus_pkg::RST_CTRL;
      chg_volt_r   <= cus_pkg::RST_CHG_VOLT;
      taper_volt_r <= cus_pkg::RST_TAPER_VOLT;
      taper_cur_r  <= cus_pkg::RST_TAPER_CUR;
      min_cap_r    <= cus_pkg::RST_MIN_CAP;
      taper_win_r  <= cus_pkg::RST_TAPER_WIN;
      set_pct_r    <= cus_pkg::RST_SET_PCT;
      clr_pct_r    <= cus_pkg::RST_CLR_PCT;
      init_stby_r  <= cus_pkg::RST_INIT_STBY;
      ml_seed_r    <= cus_pkg::RST_ML_SEED;
      deadband_r   <= cus_pkg::RST_DEADBAND;
      cc_thresh_r  <= cus_pkg::RST_CC_THRESH;
      fcc_r        <= cus_pkg::RST_FCC;
    end else if (reg_wr) begin
      unique case (reg_addr)
        cus_pkg::A_CTRL:       ctrl_r       <= reg_wdata;
        cus_pkg::A_CHG_VOLT:   chg_volt_r   <= reg_wdata;
        cus_pkg::A_TAPER_VOLT: taper_volt_r <= reg_wdata;
        cus_pkg::A_TAPER_CUR:  taper_cur_r  <= reg_wdata;
        cus_pkg::A_MIN_CAP:    min_cap_r    <= reg_wdata;
        cus_pkg::A_TAPER_WIN:  taper_win_r  <= reg_wdata;
        cus_pkg::A_SET_PCT:    set_pct_r    <= reg_wdata[7:0];
        cus_pkg::A_CLR_PCT:    clr_pct_r    <= reg_wdata[7:0];
        cus_pkg::A_INIT_STBY:  init_stby_r  <= reg_wdata;
        cus_pkg::A_ML_SEED:    ml_seed_r    <= reg_wdata;
        cus_pkg::A_DEADBAND:   deadband_r   <= reg_wdata;
        cus_pkg::A_CC_THRESH:  cc_thresh_r  <= reg_wdata;
        cus_pkg::A_FCC:        fcc_r        <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Name storage is plain data and steers nothing.
  for (genvar i = 0; i < cus_pkg::NAME_LEN; i++) begin : g_name
    always_ff @(posedge core_clk) begin
      if (srst) begin
        name_mem[i] <= NAME_INIT[55-8*i -: 8];
      end else if (reg_wr && reg_addr == 8'(cus_pkg::A_NAME_FIRST + i)) begin
        name_mem[i] <= reg_wdata[7:0];
      end
    end
  end

  // Read port: data stands only in the cycle after the strobe.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_rd) begin
      reg_rdata <= 16'h0000;
    end else if (reg_addr >= cus_pkg::A_NAME_FIRST && reg_addr <= cus_pkg::A_NAME_LAST) begin
      reg_rdata <= {8'h00, name_mem[3'(reg_addr - cus_pkg::A_NAME_FIRST)]};
    end else begin
      unique case (reg_addr)
        cus_pkg::A_CTRL:       reg_rdata <= ctrl_r;
        cus_pkg::A_STATUS:     reg_rdata <= {12'h000, tp_r == cus_pkg::TP_SECOND,
                                             tp_r != cus_pkg::TP_WAIT, chg_r, fc_r};
        cus_pkg::A_CHG_VOLT:   reg_rdata <= chg_volt_r;
        cus_pkg::A_TAPER_VOLT: reg_rdata <= taper_volt_r;
        cus_pkg::A_TAPER_CUR:  reg_rdata <= taper_cur_r;
        cus_pkg::A_MIN_CAP:    reg_rdata <= min_cap_r;
        cus_pkg::A_TAPER_WIN:  reg_rdata <= taper_win_r;
        cus_pkg::A_SET_PCT:    reg_rdata <= {8'h00, set_pct_r};
        cus_pkg::A_CLR_PCT:    reg_rdata <= {8'h00, clr_pct_r};
        cus_pkg::A_INIT_STBY:  reg_rdata <= init_stby_r;
        cus_pkg::A_ML_SEED:    reg_rdata <= ml_seed_r;
        cus_pkg::A_DEADBAND:   reg_rdata <= deadband_r;
        cus_pkg::A_CC_THRESH:  reg_rdata <= cc_thresh_r;
        cus_pkg::A_FCC:        reg_rdata <= fcc_r;
        cus_pkg::A_STBY_CUR:   reg_rdata <= stby_r;
        cus_pkg::A_MAXLOAD:    reg_rdata <= maxload_r;
        cus_pkg::A_CYCLES:     reg_rdata <= cycles_r;
        cus_pkg::A_REM_CAP:    reg_rdata <= rem_cap_r;
        cus_pkg::A_DSG_ACC:    reg_rdata <= dsg_mah_r;
        default:               reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Taper window evaluation.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tp_r        <= cus_pkg::TP_WAIT;
      start_chg_r <= 32'h0000_0000;
      win_sum_r   <= 33'sh0_0000_0000;
      win_chg_r   <= 32'h0000_0000;
      win_sec_r   <= 16'h0000;
      win_vok_r   <= 1'b1;
    end else if (tick) begin
      start_chg_r <= (chgi && !term_now) ? start_chg_r + 32'(cur_ma) : 32'h0000_0000;
      if (tp_r == cus_pkg::TP_WAIT || !chgi || !taper_mode || fc_r) begin
        tp_r      <= (armed && taper_mode && !fc_r) ? cus_pkg::TP_FIRST : cus_pkg::TP_WAIT;
        win_sum_r <= 33'sh0_0000_0000;
        win_chg_r <= 32'h0000_0000;
        win_sec_r <= 16'h0000;
        win_vok_r <= 1'b1;
      end else if (win_end) begin
        win_sum_r <= 33'sh0_0000_0000;
        win_chg_r <= 32'h0000_0000;
        win_sec_r <= 16'h0000;
        win_vok_r <= 1'b1;
        if (term_now) begin
          tp_r <= cus_pkg::TP_WAIT;
        end else if (pass) begin
          tp_r <= cus_pkg::TP_SECOND;
        end else begin
          tp_r <= cus_pkg::TP_FIRST;
        end
      end else begin
        win_sum_r <= sum_now;
        win_chg_r <= chg_now;
        win_sec_r <= win_sec_r + 16'h0001;
        win_vok_r <= win_vok_r && volt_ok;
      end
    end
  end

  // Full-charge and charging flags; in the same cycle a set wins for the full flag, a clear wins for the charging flag.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      fc_r  <= 1'b0;
      chg_r <= 1'b0;
    end else begin
      if (full_set_percent) begin
        fc_r <= 1'b1;
      end else if (fc_clr) begin
        fc_r <= 1'b0;
      end
      if (term_now || dsg) begin
        chg_r <= 1'b0;
      end else if (tick && cur_mag > deadband_r && !fc_r) begin
        chg_r <= 1'b1;
      end
    end
  end

  // Remaining capacity is only loaded here; other gauging sits outside.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rem_cap_r <= 16'h0000;
    end else if (term_now && ctrl_r[cus_pkg::CTRL_REMAINING_FROM_FULL_ON_TERM_BIT]) begin
      rem_cap_r <= fcc_r;
    end
  end

  // Standby and max-load statistics.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stby_r     <= cus_pkg::RST_INIT_STBY;
      maxload_r  <= cus_pkg::RST_ML_SEED;
      low_seen_r <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == cus_pkg::A_INIT_STBY) begin
        stby_r <= reg_wdata;
      end else if (tick && cur_mag > deadband_r
                   && 17'(cur_mag) <= (17'(init_stby_r[15] ? 16'(-init_stby_r) : init_stby_r)
                   << 1)) begin
        stby_r <= cur_ma;
      end
      if (dsg && soc_pct < cus_pkg::LOW_SOC_PCT) begin
        low_seen_r <= 1'b1;
      end else if (full_set_percent && !fc_r) begin
        low_seen_r <= 1'b0;
      end
      if (reg_wr && reg_addr == cus_pkg::A_ML_SEED) begin
        maxload_r <= reg_wdata;
      end else if (full_set_percent && !fc_r && low_seen_r) begin
        maxload_r <= ml_avg[15:0];
      end else if (tick && dsg && cur_mag > seed_mag && cur_mag > ml_mag) begin
        maxload_r <= cur_ma;
      end
    end
  end

  // Discharge accumulator: whole mAh plus a mAs remainder.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dsg_mas_r <= 12'h000;
      dsg_mah_r <= 16'h0000;
      cycles_r  <= 16'h0000;
    end else if (dsg_mah_r == cc_thresh_r && cc_thresh_r != 16'h0000) begin
      dsg_mah_r <= 16'h0000;
      cycles_r  <= cycles_r + 16'h0001;
    end else if (tick && dsg) begin
      if (32'(dsg_mas_r) + 32'(cur_mag) >= cus_pkg::MAS_PER_MAH) begin
        // Large currents add at most one mAh per second so equality is never skipped.
        dsg_mas_r <= 12'(32'(dsg_mas_r) + 32'(cur_mag) - cus_pkg::MAS_PER_MAH);
        dsg_mah_r <= dsg_mah_r + 16'h0001;
      end else begin
        dsg_mas_r <= 12'(32'(dsg_mas_r) + 32'(cur_mag));
      end
    end
  end

  assign full_charge_flag = fc_r;
  assign charging_flag    = chg_r;

  // Ticks spent in the second window, counted apart from the window timer so that the
  // two-window check does not lean on the logic that it guards.
  logic [15:0] sec_ticks_r;
  always_ff @(posedge core_clk) begin
    if (srst || tp_r != cus_pkg::TP_SECOND) begin
      sec_ticks_r <= 16'h0000;
    end else if (tick) begin
      sec_ticks_r <= sec_ticks_r + 16'h0001;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  a_term_full:  assert property (term_now |=> fc_r && !chg_r)
    else $error("termination did not set full and clear charging");
  a_term_rm:    assert property (term_now && ctrl_r[cus_pkg::CTRL_REMAINING_FROM_FULL_ON_TERM_BIT]
                                 |=> rem_cap_r == $past(fcc_r))
    else $error("remaining capacity not loaded on termination");
  a_rm_hold:    assert property (!term_now |=> rem_cap_r == $past(rem_cap_r))
    else $error("remaining capacity changed without termination");
  a_term_cur:   assert property (term_now |-> sum_now < thr_now)
    else $error("termination with window current too high");
  a_term_chg:   assert property (term_now |-> chg_now > cus_pkg::TAPER_MIN_MAS)
    else $error("termination with too little window charge");
  a_term_volt:  assert property (term_now |-> volt_mv > chg_volt_r - taper_volt_r)
    else $error("termination below voltage reference");
  a_term_mode:  assert property (term_now
                                 |-> set_pct_r == cus_pkg::TAPER_MODE_CODE)
    else $error("taper termination outside taper mode");
  a_arm_gate:   assert property (tp_r == cus_pkg::TP_WAIT
                                 ##1 tp_r == cus_pkg::TP_FIRST |-> $past(armed))
    else $error("taper evaluation began unarmed");
  a_two_win:    assert property (term_now && taper_win_r != 16'h0000
                                 |-> sec_ticks_r == taper_win_r - 16'h0001)
    else $error("termination without a full second window");
  a_fail_reset: assert property (tick && tp_r == cus_pkg::TP_SECOND && win_end
                                 && chgi && taper_mode && !fc_r && !pass
                                 |=> tp_r == cus_pkg::TP_FIRST)
    else $error("failed window kept partial qualification");
  a_pct_set:    assert property (!taper_mode && chgi && soc_pct >= set_pct_r
                                 |=> fc_r)
    else $error("full flag not set at set percentage");
  a_set_wins:   assert property (full_set_percent |=> fc_r)
    else $error("full flag set lost to a clear");
  a_full_clear_percent:   assert property (fc_r && dsg && soc_pct <= clr_pct_r && !full_set_percent
                                 |=> !fc_r)
    else $error("full flag not cleared at clear percentage");
  a_stby_upd:   assert property (stby_r != $past(stby_r)
                                 |-> $past(tick) || $past(reg_wr))
    else $error("standby current moved off the one-second tick");
  a_ml_grow:    assert property (tick && dsg && cur_mag > seed_mag
                                 && cur_mag > ml_mag && !reg_wr && !(full_set_percent && !fc_r && low_seen_r)
                                 |=> maxload_r == $past(cur_ma))
    else $error("max-load not replaced by a larger discharge");
  a_cycle_inc:  assert property (cycles_r != $past(cycles_r)
                                 |-> $past(dsg_mah_r) == $past(cc_thresh_r)
                                     && dsg_mah_r == 16'h0000)
    else $error("cycle count moved without threshold");
  a_acc_hold:   assert property (dsg_mah_r < $past(dsg_mah_r)
                                 |-> cycles_r == $past(cycles_r) + 16'h0001)
    else $error("discharge accumulator cleared early");
  a_name_read:  assert property (reg_rd && reg_addr == cus_pkg::A_NAME_FIRST
                                 |=> reg_rdata == {8'h00, name_mem[0]})
    else $error("name byte read wrong");
  a_ml_avg:     assert property (full_set_percent && !fc_r && low_seen_r && !reg_wr
                                 |=> maxload_r == $past(ml_avg[15:0]))
    else $error("max-load not averaged after full charge");

  c_term:   cover property (term_now);
  c_retry:  cover property (tp_r == cus_pkg::TP_SECOND ##1 tp_r == cus_pkg::TP_FIRST);
  c_cycle:  cover property (cycles_r != $past(cycles_r));
  c_pct_fc: cover property (!taper_mode && full_set_percent && !fc_r);
  c_fc_clr: cover property ($fell(fc_r));
endmodule

// >>> dv/testbench.sv
// Self-checking testbench for the charge termination and usage statistics block.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, exp, got); end end
module testbench;
  localparam int unsigned TICKS = 10;
  localparam logic [55:0] NAME  = 56'h54_45_53_54_47_41_47;
  logic               core_clk;
  logic               srst;
  logic signed [15:0] cur_ma;
  logic [15:0]        volt_mv;
  logic [7:0]         soc_pct;
  logic [7:0]         reg_addr;
  logic [15:0]        reg_wdata;
  logic               reg_wr;
  logic               reg_rd;
  logic [15:0]        reg_rdata;
  logic               full_charge_flag;
  logic               charging_flag;
  int                 mismatches;
  int                 total_checks;
  int                 cyc;
  logic [15:0]        rv;
  cus_gauge #(.TICK_CYCLES(TICKS), .NAME_INIT(NAME)) dut_u (
    .core_clk         (core_clk),
    .srst             (srst),
    .cur_ma           (cur_ma),
    .volt_mv          (volt_mv),
    .soc_pct          (soc_pct),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_wr           (reg_wr),
    .reg_rd           (reg_rd),
    .reg_rdata        (reg_rdata),
    .full_charge_flag (full_charge_flag),
    .charging_flag    (charging_flag)
  );
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    cur_ma = 16'sh0000;
    volt_mv = 16'h0000;
    soc_pct = 8'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
  end
  always #20 core_clk = ~core_clk;
  task automatic give_verdict();
    $display("checks made %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The run is a few thousand cycles; this ceiling only cuts a hang short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      mismatches++;
      give_verdict();
    end
  end
  // Every task starts just after a rising edge and returns just after one.
  task automatic do_reset();
    srst <= 1'b1;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    @(posedge core_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] d;
    rd(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic wait_full(input int bound);
    for (int i = 0; i < bound && full_charge_flag !== 1'b1; i++) @(posedge core_clk);
  endtask
  // Short windows keep the run brief: 11 ticks at 90 mA give 990 mA*s per window.
  task automatic taper_cfg(input logic signed [15:0] i, input logic [15:0] v);
    wr(cus_pkg::A_TAPER_WIN, 16'h000B);
    wr(cus_pkg::A_MIN_CAP, 16'h0064);
    volt_mv <= v;
    cur_ma <= i;
    soc_pct <= 8'h50;
  endtask
  initial begin
    do_reset();
    rc(cus_pkg::A_TAPER_CUR, 16'h0064, "taper current");
    rc(cus_pkg::A_CC_THRESH, 16'h0384, "cycle threshold");
    rc(cus_pkg::A_CHG_VOLT, 16'h1068, "charging voltage");
    rc(cus_pkg::A_TAPER_WIN, 16'h0028, "taper window");
    rc(cus_pkg::A_SET_PCT, 16'h00FF, "set percent");
    rc(cus_pkg::A_CLR_PCT, 16'h0062, "clear percent");
    rc(cus_pkg::A_STBY_CUR, 16'hFFF6, "standby seed");
    rc(cus_pkg::A_MAXLOAD, 16'hFE0C, "maxload seed");
    for (int k = 0; k < 7; k++) begin
      rc(8'(8'h63 + k), {8'h00, NAME[55 - 8 * k -: 8]}, "name byte");
    end
    rc(8'h6A, 16'h0000, "unmapped read");
    wr(cus_pkg::A_STBY_CUR, 16'h1234);
    rc(cus_pkg::A_STBY_CUR, 16'hFFF6, "read-only write");
    // Taper termination: must not declare after a single window.
    taper_cfg(16'sd90, 16'h1036);
    repeat (20 * TICKS) @(posedge core_clk);
    `CHK("full after one window", 1'b0, full_charge_flag)
    wait_full(40 * TICKS);
    @(posedge core_clk);
    `CHK("full on termination", 1'b1, full_charge_flag)
    `CHK("charging on termination", 1'b0, charging_flag)
    rc(cus_pkg::A_REM_CAP, 16'h03E8, "remaining loaded");
    rc(cus_pkg::A_STATUS, 16'h0001, "status after termination");
    // Failing current, voltage or window charge must never terminate; the last run fails
    // its second window, then needs two fresh windows, with the load-on-full bit clear.
    for (int k = 0; k < 4; k++) begin
      do_reset();
      if (k == 3) begin
        wr(cus_pkg::A_CTRL, 16'h0000);
      end
      taper_cfg(k == 0 ? 16'sd150 : (k == 2 ? 16'sd50 : 16'sd90), k == 1 ? 16'h1000 : 16'h1036);
      repeat (18 * TICKS) @(posedge core_clk);
      if (k == 3) begin
        cur_ma <= 16'sd150;
      end
      repeat (40 * TICKS) @(posedge core_clk);
      `CHK("no termination", 1'b0, full_charge_flag)
    end
    cur_ma <= 16'sd90;
    wait_full(40 * TICKS);
    @(posedge core_clk);
    `CHK("full after restart", 1'b1, full_charge_flag)
    rc(cus_pkg::A_REM_CAP, 16'h0000, "remaining kept");
    // Deep discharge counts cycles, tracks max load, then a percent-mode full charge.
    do_reset();
    wr(cus_pkg::A_CC_THRESH, 16'h0003);
    cur_ma <= -16'sd3600;
    soc_pct <= 8'h28;
    rv = 16'h0000;
    for (int i = 0; i < 100 && rv !== 16'h0001; i++) rd(cus_pkg::A_CYCLES, rv);
    `CHK("cycle count", 16'h0001, rv)
    rd(cus_pkg::A_DSG_ACC, rv);
    `CHK("accumulator wrapped", 1'b1, rv < 16'h0003)
    rc(cus_pkg::A_MAXLOAD, 16'hF1F0, "maxload replaced");
    wr(cus_pkg::A_SET_PCT, 16'h005A);
    cur_ma <= 16'sd200;
    soc_pct <= 8'h5F;
    wait_full(10 * TICKS);
    @(posedge core_clk);
    `CHK("full by percent", 1'b1, full_charge_flag)
    rc(cus_pkg::A_MAXLOAD, 16'hF7FE, "maxload averaged");
    cur_ma <= -16'sd8;
    soc_pct <= 8'h62;
    repeat (3 * TICKS) @(posedge core_clk);
    `CHK("full cleared", 1'b0, full_charge_flag)
    rc(cus_pkg::A_STBY_CUR, 16'hFFF8, "standby updated");
    give_verdict();
  end
endmodule
